// ==== design/t1f_framer.sv ====
// t1 block framer, card side: block parse, check, build and sequencing
`timescale 1ns/1ps
`default_nettype none
module t1f_framer
    import t1f_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_par_err,
    output logic             tx_valid,
    output logic      [7:0]  tx_data,
    input  wire logic        tx_ready,
    input  wire logic        app_tx_valid,
    input  wire logic [7:0]  app_tx_data,
    output logic             app_tx_ready,
    output logic             app_rx_valid,
    output logic      [7:0]  app_rx_data,
    output logic             blk_ok,
    output logic             blk_err,
    output logic             wtx_granted,
    output logic             resync_done
);
    t1f_rx_t     rx_st_q;
    t1f_tx_t     tx_st_q;
    logic [7:0]  rx_nad_q, rx_pcb_q, rx_len_q, rx_cnt_q, rx_lrc_q, rx_sinf_q;
    logic        rx_perr_q;
    logic        ns_q, nr_q, own_q, first_q, spend_q, bad_q, lsi_q;
    logic [4:0]  spend_fn_q;
    logic [7:0]  ifs_q;
    logic        auto_q;
    logic [7:0]  auto_nad_q, auto_pcb_q, auto_len_q, auto_inf_q;
    logic        cmd_q, cmd_s_q, cmd_m_q;
    logic [4:0]  cmd_fn_q;
    logic [7:0]  cmd_byte_q;
    logic [7:0]  tx_nad_q, tx_pcb_q, tx_len_q, tx_inf_q, tx_cnt_q, tx_lrc_q;
    logic        tx_app_q, tx_full_q;
    logic        ack_q;

    // received block decode
    wire        blk_end  = rx_valid & (rx_st_q == RX_EDC);
    wire        lrc_ok   = (rx_lrc_q == rx_data);
    wire        par_bad  = rx_perr_q | rx_par_err;
    wire        is_i     = ~rx_pcb_q[7];
    wire        is_r     = (rx_pcb_q[7:5] == T1F_PCB_R);
    wire        is_s     = (rx_pcb_q[7:6] == T1F_PCB_S);
    wire [4:0]  s_fn     = rx_pcb_q[4:0];
    wire        s_resp   = rx_pcb_q[5];
    wire        s_one    = (s_fn == T1F_S_IFS) | (s_fn == T1F_S_WTX);
    wire        s_glob   = (s_fn == T1F_S_IFS) | (s_fn == T1F_S_RESYNC);
    wire [7:0]  s_len    = s_one ? T1F_LEN_ONE : T1F_LEN_NONE;
    wire        i_ok     = is_i & (rx_pcb_q[4:0] == 5'h00);
    wire        r_code   = (rx_pcb_q[3:0] <= T1F_R_OTHER);
    wire        r_ok     = is_r & r_code & (rx_len_q == T1F_LEN_NONE)
                           & ~first_q;
    wire        s_ok     = is_s & (s_fn <= T1F_S_WTX)
                           & (rx_len_q == s_len);
    wire        nad_lsi  = ~rx_nad_q[7] & ~rx_nad_q[3]
                           & ~(is_s & s_glob & (rx_nad_q != T1F_NAD_DEF));
    wire        nad_ok   = lsi_q ? nad_lsi : (rx_nad_q == T1F_NAD_DEF);
    wire        good     = lrc_ok & ~par_bad & nad_ok
                           & (i_ok | r_ok | s_ok)
                           & (rx_len_q != T1F_LEN_RFU);
    wire [3:0]  bad_code = (~lrc_ok | par_bad) ? T1F_R_EDC : T1F_R_OTHER;

    // sequencing events
    wire        ok_end   = blk_end & good;
    wire        got_i    = ok_end & is_i;
    wire        got_sreq = ok_end & is_s & ~s_resp;
    wire        got_sres = ok_end & is_s & s_resp;
    wire        chained  = got_i & rx_pcb_q[5];
    wire        need_r   = chained | (blk_end & ~good);
    wire        sres_hit = got_sres & spend_q & (s_fn == spend_fn_q);
    wire        do_sync  = got_sreq & (s_fn == T1F_S_RESYNC);
    wire        do_ifs   = got_sreq & (s_fn == T1F_S_IFS);
    wire [7:0]  nad_swap = {1'b0, rx_nad_q[2:0], 1'b0, rx_nad_q[6:4]};
    wire [7:0]  nad_rep  = lsi_q ? nad_swap : T1F_NAD_DEF;
    wire        r_nr     = chained ? ~rx_pcb_q[6] : nr_q;
    wire [3:0]  r_code_o = chained ? T1F_R_OK : bad_code;
    wire [7:0]  r_pcb    = {T1F_PCB_R, r_nr, r_code_o};
    wire [7:0]  sr_pcb   = {T1F_PCB_S, 1'b1, s_fn};
    wire [7:0]  sr_nad   = s_glob ? T1F_NAD_DEF : nad_rep;

    // transmit start selection
    wire        tx_idle  = (tx_st_q == TX_IDLE);
    wire        tx_go    = own_q & tx_idle & (auto_q | cmd_q);
    wire        go_auto  = tx_go & auto_q;
    wire        go_cmd   = tx_go & ~auto_q;
    wire        cmd_one  = (cmd_fn_q == T1F_S_IFS) | (cmd_fn_q == T1F_S_WTX);
    wire        cmd_glob = (cmd_fn_q == T1F_S_IFS) | (cmd_fn_q == T1F_S_RESYNC);
    wire [7:0]  ci_pcb   = {1'b0, ns_q, cmd_m_q, 5'h00};
    wire [7:0]  cs_pcb   = {T1F_PCB_S, 1'b0, cmd_fn_q};
    wire [7:0]  cs_len   = cmd_one ? T1F_LEN_ONE : T1F_LEN_NONE;
    wire [7:0]  cs_nad   = cmd_glob ? T1F_NAD_DEF : nad_rep;
    wire [7:0]  c_pcb    = cmd_s_q ? cs_pcb : ci_pcb;
    wire [7:0]  c_len    = cmd_s_q ? cs_len : cmd_byte_q;
    wire [7:0]  c_nad    = cmd_s_q ? cs_nad : nad_rep;

    // transmit byte stream
    wire        tx_busy  = ~tx_idle & (tx_st_q != TX_END);
    wire        tx_src   = (tx_st_q == TX_INF) & tx_app_q;
    wire        tx_load  = ~tx_full_q & tx_busy & (~tx_src | app_tx_valid);
    wire        tx_done  = (tx_st_q == TX_END) & ~tx_full_q;
    wire [7:0]  tx_infb  = tx_app_q ? app_tx_data : tx_inf_q;
    wire [7:0]  tx_next  = (tx_st_q == TX_NAD) ? tx_nad_q :
                           (tx_st_q == TX_PCB) ? tx_pcb_q :
                           (tx_st_q == TX_LEN) ? tx_len_q :
                           (tx_st_q == TX_INF) ? tx_infb  : tx_lrc_q;
    wire        tx_last  = (tx_cnt_q == tx_len_q - 8'h01);
    assign app_tx_ready = ~tx_full_q & tx_src;
    assign tx_valid     = tx_full_q;

    // register bus decode
    wire        bus_req  = avs_read | avs_write;
    wire        wr_en    = avs_write & ack_q;
    wire        wr_ctrl  = wr_en & (avs_address == T1F_OFS_CTRL);
    wire        wr_ifs   = wr_en & (avs_address == T1F_OFS_IFS);
    wire        wr_cmd   = wr_en & (avs_address == T1F_OFS_TXCMD);
    wire        w_s      = avs_writedata[T1F_CMD_S];
    wire        cmd_take = wr_cmd & ~cmd_q
                           & (w_s | (avs_writedata[7:0] != T1F_LEN_RFU));
    wire [31:0] stat_w   = {23'h0, bad_q, first_q, cmd_q, auto_q, nr_q, ns_q,
                            spend_q, tx_busy, own_q};
    wire [31:0] rd_mux   =
        (avs_address == T1F_OFS_CTRL)  ? {31'h0, lsi_q} :
        (avs_address == T1F_OFS_STAT)  ? stat_w :
        (avs_address == T1F_OFS_IFS)   ? {24'h0, ifs_q} :
        (avs_address == T1F_OFS_RXHDR) ? {8'h0, rx_nad_q, rx_pcb_q, rx_len_q} :
        32'h0;
    assign avs_waitrequest = bus_req & ~ack_q;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ack_q        <= 1'b0;
            avs_readdata <= 32'h0;
        end else begin
            ack_q <= bus_req & ~ack_q;
            if (bus_req & ~ack_q) begin
                avs_readdata <= rd_mux;
            end
        end
    end

    // receive framing
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rx_st_q   <= RX_NAD;
            rx_nad_q  <= 8'h00;
            rx_pcb_q  <= 8'h00;
            rx_len_q  <= 8'h00;
            rx_cnt_q  <= 8'h00;
            rx_lrc_q  <= 8'h00;
            rx_sinf_q <= 8'h00;
            rx_perr_q <= 1'b0;
        end else if (rx_valid) begin
            rx_lrc_q  <= (rx_st_q == RX_NAD) ? rx_data : rx_lrc_q ^ rx_data;
            rx_perr_q <= (rx_st_q == RX_NAD) ? rx_par_err : par_bad;
            unique case (rx_st_q)
                RX_NAD: begin
                    rx_nad_q <= rx_data;
                    rx_st_q  <= RX_PCB;
                end
                RX_PCB: begin
                    rx_pcb_q <= rx_data;
                    rx_st_q  <= RX_LEN;
                end
                RX_LEN: begin
                    rx_len_q <= rx_data;
                    rx_cnt_q <= 8'h00;
                    rx_st_q  <= (rx_data == T1F_LEN_NONE) ? RX_EDC : RX_INF;
                end
                RX_INF: begin
                    if (rx_cnt_q == 8'h00) begin
                        rx_sinf_q <= rx_data;
                    end
                    rx_cnt_q <= rx_cnt_q + 8'h01;
                    if (rx_cnt_q == rx_len_q - 8'h01) begin
                        rx_st_q <= RX_EDC;
                    end
                end
                RX_EDC: rx_st_q <= RX_NAD;
                default: rx_st_q <= RX_NAD;
            endcase
        end
    end

    // sequence counters, turn and supervisory state
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ns_q       <= 1'b0;
            nr_q       <= 1'b0;
            own_q      <= 1'b0;
            first_q    <= 1'b1;
            bad_q      <= 1'b0;
            spend_q    <= 1'b0;
            spend_fn_q <= 5'h00;
        end else begin
            if (do_sync) begin
                ns_q <= 1'b0;
                nr_q <= 1'b0;
            end else begin
                if (go_cmd & ~cmd_s_q) begin
                    ns_q <= ~ns_q;
                end
                if (got_i) begin
                    nr_q <= ~rx_pcb_q[6];
                end
            end
            if (blk_end) begin
                own_q   <= 1'b1;
                first_q <= 1'b0;
                bad_q   <= ~good;
            end else if (tx_done) begin
                own_q <= 1'b0;
            end
            if (go_cmd & cmd_s_q) begin
                spend_q    <= 1'b1;
                spend_fn_q <= cmd_fn_q;
            end else if (sres_hit) begin
                spend_q <= 1'b0;
            end
        end
    end

    // automatic replies: R acknowledge or S response
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            auto_q     <= 1'b0;
            auto_nad_q <= 8'h00;
            auto_pcb_q <= 8'h00;
            auto_len_q <= 8'h00;
            auto_inf_q <= 8'h00;
        end else if (need_r) begin
            auto_q     <= 1'b1;
            auto_nad_q <= nad_rep;
            auto_pcb_q <= r_pcb;
            auto_len_q <= T1F_LEN_NONE;
        end else if (got_sreq) begin
            auto_q     <= 1'b1;
            auto_nad_q <= sr_nad;
            auto_pcb_q <= sr_pcb;
            auto_len_q <= rx_len_q;
            auto_inf_q <= rx_sinf_q;
        end else if (go_auto) begin
            auto_q <= 1'b0;
        end
    end

    // software command, control and IFS registers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cmd_q      <= 1'b0;
            cmd_s_q    <= 1'b0;
            cmd_m_q    <= 1'b0;
            cmd_fn_q   <= 5'h00;
            cmd_byte_q <= 8'h00;
            lsi_q      <= 1'b0;
            ifs_q      <= T1F_IFS_RST;
        end else begin
            if (cmd_take) begin
                cmd_q      <= 1'b1;
                cmd_s_q    <= w_s;
                cmd_m_q    <= avs_writedata[T1F_CMD_M];
                cmd_fn_q   <= avs_writedata[T1F_CMD_FN +: 5];
                cmd_byte_q <= avs_writedata[7:0];
            end else if (go_cmd) begin
                cmd_q <= 1'b0;
            end
            if (wr_ctrl) begin
                lsi_q <= avs_writedata[0];
            end
            if (do_ifs) begin
                ifs_q <= rx_sinf_q;
            end else if (wr_ifs) begin
                ifs_q <= avs_writedata[7:0];
            end
        end
    end

    // block builder
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tx_st_q   <= TX_IDLE;
            tx_nad_q  <= 8'h00;
            tx_pcb_q  <= 8'h00;
            tx_len_q  <= 8'h00;
            tx_inf_q  <= 8'h00;
            tx_cnt_q  <= 8'h00;
            tx_lrc_q  <= 8'h00;
            tx_app_q  <= 1'b0;
            tx_full_q <= 1'b0;
            tx_data   <= 8'h00;
        end else if (tx_go) begin
            tx_st_q  <= TX_NAD;
            tx_nad_q <= auto_q ? auto_nad_q : c_nad;
            tx_pcb_q <= auto_q ? auto_pcb_q : c_pcb;
            tx_len_q <= auto_q ? auto_len_q : c_len;
            tx_inf_q <= auto_q ? auto_inf_q : cmd_byte_q;
            tx_app_q <= ~auto_q & ~cmd_s_q;
            tx_cnt_q <= 8'h00;
        end else if (tx_load) begin
            tx_data   <= tx_next;
            tx_full_q <= 1'b1;
            tx_lrc_q  <= (tx_st_q == TX_NAD) ? tx_next : tx_lrc_q ^ tx_next;
            unique case (tx_st_q)
                TX_NAD: tx_st_q <= TX_PCB;
                TX_PCB: tx_st_q <= TX_LEN;
                TX_LEN: tx_st_q <= (tx_len_q == T1F_LEN_NONE) ? TX_EDC : TX_INF;
                TX_INF: begin
                    tx_cnt_q <= tx_cnt_q + 8'h01;
                    if (tx_last) begin
                        tx_st_q <= TX_EDC;
                    end
                end
                TX_EDC: tx_st_q <= TX_END;
                default: tx_st_q <= TX_IDLE;
            endcase
        end else if (tx_full_q & tx_ready) begin
            tx_full_q <= 1'b0;
        end else if (tx_done) begin
            tx_st_q <= TX_IDLE;
        end
    end

    // user side strobes
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            app_rx_valid <= 1'b0;
            app_rx_data  <= 8'h00;
            blk_ok       <= 1'b0;
            blk_err      <= 1'b0;
            wtx_granted  <= 1'b0;
            resync_done  <= 1'b0;
        end else begin
            app_rx_valid <= rx_valid & (rx_st_q == RX_INF) & is_i;
            app_rx_data  <= rx_data;
            blk_ok       <= ok_end;
            blk_err      <= blk_end & ~good;
            wtx_granted  <= sres_hit & (s_fn == T1F_S_WTX);
            resync_done  <= do_sync;
        end
    end
endmodule
`default_nettype wire

// ==== design/t1f_pkg.sv ====
// t1 block framer package: offsets, codes, reset values and state types
package t1f_pkg;
    localparam logic [4:0] T1F_OFS_CTRL  = 5'h00;
    localparam logic [4:0] T1F_OFS_TXCMD = 5'h04;
    localparam logic [4:0] T1F_OFS_STAT  = 5'h08;
    localparam logic [4:0] T1F_OFS_IFS   = 5'h0c;
    localparam logic [4:0] T1F_OFS_RXHDR = 5'h10;
    localparam int         T1F_CMD_M     = 8;
    localparam int         T1F_CMD_S     = 9;
    localparam int         T1F_CMD_FN    = 10;
    localparam logic [7:0] T1F_LEN_NONE  = 8'h00;
    localparam logic [7:0] T1F_LEN_ONE   = 8'h01;
    localparam logic [7:0] T1F_LEN_RFU   = 8'hff;
    localparam logic [7:0] T1F_NAD_DEF   = 8'h00;
    localparam logic [7:0] T1F_IFS_RST   = 8'h20;
    localparam logic [3:0] T1F_R_OK      = 4'h0;
    localparam logic [3:0] T1F_R_EDC     = 4'h1;
    localparam logic [3:0] T1F_R_OTHER   = 4'h2;
    localparam logic [4:0] T1F_S_RESYNC  = 5'h00;
    localparam logic [4:0] T1F_S_IFS     = 5'h01;
    localparam logic [4:0] T1F_S_ABORT   = 5'h02;
    localparam logic [4:0] T1F_S_WTX     = 5'h03;
    localparam logic [4:0] T1F_S_VPP     = 5'h04;
    localparam logic [2:0] T1F_PCB_R     = 3'h4;
    localparam logic [1:0] T1F_PCB_S     = 2'h3;

    typedef enum logic [4:0] {
        RX_NAD = 5'h01,
        RX_PCB = 5'h02,
        RX_LEN = 5'h04,
        RX_INF = 5'h08,
        RX_EDC = 5'h10
    } t1f_rx_t;

    typedef enum logic [6:0] {
        TX_IDLE = 7'h01,
        TX_NAD  = 7'h02,
        TX_PCB  = 7'h04,
        TX_LEN  = 7'h08,
        TX_INF  = 7'h10,
        TX_EDC  = 7'h20,
        TX_END  = 7'h40
    } t1f_tx_t;
endpackage

// ==== verif/t1f_framer_monitor.sv ====
// concurrent checks on the framer ports
`timescale 1ns/1ps
`default_nettype none
module t1f_framer_monitor (
    input wire logic       core_clk,
    input wire logic       nrst,
    input wire logic       rx_valid,
    input wire logic       tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic       tx_ready,
    input wire logic       app_rx_valid,
    input wire logic       blk_ok,
    input wire logic       blk_err,
    input wire logic       wtx_granted,
    input wire logic       resync_done
);
    logic seen_q;
    // any character received since reset
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            seen_q <= 1'b0;
        end else if (rx_valid) begin
            seen_q <= 1'b1;
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("tx byte dropped or changed before accept");
    a_tx_gap: assert property (tx_valid && tx_ready |=> !tx_valid)
        else $error("no gap after accepted tx byte");
    a_no_first_tx: assert property (tx_valid |-> seen_q)
        else $error("card sent before any block received");
    a_verdict_after_rx: assert property (blk_ok || blk_err |-> $past(rx_valid))
        else $error("block verdict without closing character");
    a_ok_err_excl: assert property (!(blk_ok && blk_err))
        else $error("block both valid and invalid");
    a_app_after_rx: assert property (app_rx_valid |-> $past(rx_valid))
        else $error("inf byte without received character");
    a_wtx_valid: assert property (wtx_granted |-> $past(rx_valid) && !blk_err)
        else $error("wtx grant without valid response");
    a_resync_valid: assert property (resync_done |-> $past(rx_valid) && !blk_err)
        else $error("resync without valid request");
endmodule
bind t1f_framer t1f_framer_monitor mon_u (
    .core_clk(core_clk), .nrst(nrst), .rx_valid(rx_valid), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .app_rx_valid(app_rx_valid), .blk_ok(blk_ok),
    .blk_err(blk_err), .wtx_granted(wtx_granted), .resync_done(resync_done)
);
`default_nettype wire

// ==== verif/t1f_term_model.sv ====
// terminal partner model: block sender and collector of card bytes
`timescale 1ns/1ps
`default_nettype none
module t1f_term_model (
    input  wire logic       core_clk,
    output logic            rx_valid,
    output logic      [7:0] rx_data,
    output logic            rx_par_err,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready
);
    logic       slow;
    logic [7:0] got_q[$];
    initial begin
        slow = 1'b0;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_par_err = 1'b0;
        tx_ready = 1'b1;
    end
    // collect accepted bytes; stall every other cycle when slow
    always @(posedge core_clk) begin
        if (tx_valid && tx_ready) begin
            got_q.push_back(tx_data);
        end
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end
    // whole block back to back: nad, pcb, len, inf, lrc
    task automatic send_blk(input logic [7:0] nad, input logic [7:0] pcb,
                            input logic [7:0] len, input logic [7:0] inf0, input logic bad);
        logic [7:0] b[$];
        logic [7:0] edc;
        b = {nad, pcb, len};
        for (int i = 0; i < len; i++) b.push_back(inf0 + 8'(i));
        edc = 8'h00;
        foreach (b[i]) edc ^= b[i];
        b.push_back(bad ? ~edc : edc);
        foreach (b[i]) begin
            @(posedge core_clk);
            rx_valid <= 1'b1;
            rx_data <= b[i];
        end
        @(posedge core_clk);
        rx_valid <= 1'b0;
        rx_data <= ~b[b.size() - 1];
    endtask
endmodule
`default_nettype wire

// ==== verif/t1_block_link_framer_tb_top.sv ====
// directed testbench for the card-side block framer
`timescale 1ns/1ps
`default_nettype none
module t1_block_link_framer_tb_top;
    import t1f_pkg::*;
    logic        core_clk;
    logic        nrst;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        rx_valid;
    logic [7:0]  rx_data;
    logic        rx_par_err;
    logic        tx_valid;
    logic [7:0]  tx_data;
    logic        tx_ready;
    logic        app_tx_valid;
    logic [7:0]  app_tx_data;
    logic        app_tx_ready;
    logic        app_rx_valid;
    logic [7:0]  app_rx_data;
    logic        blk_ok;
    logic        blk_err;
    logic        wtx_granted;
    logic        resync_done;
    logic [3:0]  ev;
    logic [31:0] rd;
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          n_app = 0;
    int          n_pull = 0;
    logic [7:0]  app_last;
    logic [7:0]  exp_nad = T1F_NAD_DEF;
    assign ev = {resync_done, wtx_granted, blk_err, blk_ok};
    t1f_framer dut_u (
        .core_clk(core_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_par_err(rx_par_err), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .app_tx_valid(app_tx_valid), .app_tx_data(app_tx_data), .app_tx_ready(app_tx_ready),
        .app_rx_valid(app_rx_valid), .app_rx_data(app_rx_data), .blk_ok(blk_ok),
        .blk_err(blk_err), .wtx_granted(wtx_granted), .resync_done(resync_done)
    );
    t1f_term_model term_u (
        .core_clk(core_clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_par_err(rx_par_err),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready)
    );
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (app_rx_valid === 1'b1) begin
            n_app <= n_app + 1;
            app_last <= app_rx_data;
        end
        if (app_tx_ready === 1'b1 && app_tx_valid === 1'b1) n_pull <= n_pull + 1;
    end
    task automatic print_verdict;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            n_mismatch++;
        end
    endtask
    task automatic bus(input logic [4:0] a, input logic wr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= wd;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        if (avs_waitrequest !== 1'b0) chk("bus answer", 32'h0, 32'h1);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 20) print_verdict();
    endtask
    task automatic wait_ev(input string nm, input logic [3:0] exp);
        int n;
        n = 0;
        while ((ev & exp) === 4'h0 && n < 600) begin
            @(posedge core_clk);
            n++;
        end
        chk(nm, {28'h0, exp}, {28'h0, ev});
        if (n >= 600) print_verdict();
    endtask
    task automatic expect_blk(input string nm, input logic [7:0] pcb, input logic [7:0] len,
                              input logic [7:0] inf0);
        logic [7:0] e[$];
        logic [7:0] x;
        int n;
        e = {exp_nad, pcb, len};
        for (int i = 0; i < len; i++) e.push_back(inf0 + 8'(i));
        x = 8'h00;
        foreach (e[i]) x ^= e[i];
        e.push_back(x);
        n = 0;
        while (term_u.got_q.size() < e.size() && n < 400) begin
            @(posedge core_clk);
            n++;
        end
        chk({nm, " bytes"}, 32'(e.size()), 32'(term_u.got_q.size()));
        if (n >= 400) print_verdict();
        foreach (e[i]) chk(nm, {24'h0, e[i]}, {24'h0, term_u.got_q[i]});
        term_u.got_q.delete();
    endtask
    task automatic t_regs;
        bus(T1F_OFS_IFS, 1'b0, 32'h0);
        chk("ifs reset", {24'h0, T1F_IFS_RST}, rd);
        bus(T1F_OFS_STAT, 1'b0, 32'h0);
        chk("first flag", 32'h1, {31'h0, rd[7]});
        bus(5'h14, 1'b1, 32'hffffffff);
        bus(5'h14, 1'b0, 32'h0);
        chk("unmapped", 32'h0, rd);
    endtask
    task automatic t_first_r;
        term_u.send_blk(8'h00, 8'h80, 8'h00, 8'h00, 1'b0);
        wait_ev("first r", 4'h2);
        expect_blk("r other", {T1F_PCB_R, 1'b0, T1F_R_OTHER}, 8'h00, 8'h00);
    endtask
    task automatic t_ifs;
        term_u.slow <= 1'b1;
        term_u.send_blk(8'h00, {T1F_PCB_S, 1'b0, T1F_S_IFS}, 8'h01, 8'h40, 1'b0);
        wait_ev("ifs req", 4'h1);
        expect_blk("ifs resp", {T1F_PCB_S, 1'b1, T1F_S_IFS}, 8'h01, 8'h40);
        bus(T1F_OFS_IFS, 1'b0, 32'h0);
        chk("ifs new", 32'h40, rd);
        term_u.slow <= 1'b0;
    endtask
    task automatic t_chain;
        int n0;
        n0 = n_app;
        term_u.send_blk(8'h00, 8'h20, 8'h02, 8'h11, 1'b0);
        wait_ev("chain ok", 4'h1);
        chk("inf count", 32'h2, 32'(n_app - n0));
        chk("inf data", 32'h12, {24'h0, app_last});
        expect_blk("chain ack", {T1F_PCB_R, 1'b1, T1F_R_OK}, 8'h00, 8'h00);
    endtask
    task automatic t_invalid;
        term_u.send_blk(8'h00, 8'h40, 8'h00, 8'h00, 1'b1);
        wait_ev("bad lrc", 4'h2);
        expect_blk("r edc", {T1F_PCB_R, 1'b1, T1F_R_EDC}, 8'h00, 8'h00);
        term_u.rx_par_err <= 1'b1;
        term_u.send_blk(8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
        term_u.rx_par_err <= 1'b0;
        wait_ev("parity", 4'h2);
        expect_blk("r parity", {T1F_PCB_R, 1'b1, T1F_R_EDC}, 8'h00, 8'h00);
        term_u.send_blk(8'h00, {T1F_PCB_S, 1'b0, T1F_S_VPP}, 8'h00, 8'h00, 1'b0);
        wait_ev("vpp code", 4'h2);
        expect_blk("r vpp", {T1F_PCB_R, 1'b1, T1F_R_OTHER}, 8'h00, 8'h00);
        term_u.send_blk(8'h00, 8'h00, T1F_LEN_RFU, 8'h00, 1'b0);
        wait_ev("len ff", 4'h2);
        expect_blk("r len", {T1F_PCB_R, 1'b1, T1F_R_OTHER}, 8'h00, 8'h00);
    endtask
    task automatic t_wtx_iblk;
        term_u.send_blk(8'h00, 8'h40, 8'h01, 8'h33, 1'b0);
        wait_ev("plain i", 4'h1);
        bus(T1F_OFS_STAT, 1'b0, 32'h0);
        chk("own turn", 32'h1, {31'h0, rd[0]});
        bus(T1F_OFS_TXCMD, 1'b1, (32'(T1F_S_WTX) << T1F_CMD_FN) | (32'h1 << T1F_CMD_S) | 32'h5);
        expect_blk("wtx req", {T1F_PCB_S, 1'b0, T1F_S_WTX}, 8'h01, 8'h05);
        term_u.send_blk(8'h00, {T1F_PCB_S, 1'b1, T1F_S_WTX}, 8'h01, 8'h05, 1'b0);
        wait_ev("wtx grant", 4'h5);
        app_tx_data <= 8'h5a;
        app_tx_valid <= 1'b1;
        bus(T1F_OFS_TXCMD, 1'b1, 32'h1);
        expect_blk("first i", 8'h00, 8'h01, 8'h5a);
        chk("app pull", 32'h1, 32'(n_pull));
        app_tx_valid <= 1'b0;
    endtask
    task automatic t_resync;
        term_u.send_blk(8'h00, {T1F_PCB_S, 1'b0, T1F_S_RESYNC}, 8'h00, 8'h00, 1'b0);
        wait_ev("resync", 4'h9);
        expect_blk("resync resp", {T1F_PCB_S, 1'b1, T1F_S_RESYNC}, 8'h00, 8'h00);
        bus(T1F_OFS_STAT, 1'b0, 32'h0);
        chk("counters zero", 32'h0, {30'h0, rd[4:3]});
    endtask
    task automatic t_lsi;
        bus(T1F_OFS_CTRL, 1'b1, 32'h1);
        term_u.send_blk(8'h12, 8'h20, 8'h01, 8'h44, 1'b0);
        wait_ev("lsi chain", 4'h1);
        exp_nad = 8'h21;
        expect_blk("lsi ack", {T1F_PCB_R, 1'b1, T1F_R_OK}, 8'h00, 8'h00);
        exp_nad = T1F_NAD_DEF;
    endtask
    initial begin
        nrst = 1'b0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        app_tx_valid = 1'b0;
        app_tx_data = 8'h00;
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        t_regs();
        t_first_r();
        t_ifs();
        t_chain();
        t_invalid();
        t_wtx_iblk();
        t_resync();
        t_lsi();
        print_verdict();
    end
endmodule
`default_nettype wire
